// ---- logic/tap_pkg.sv ----
// Purpose: shared constants and types for the boundary-scan test port
// Assumes: four-bit instruction register, one-hot controller state codes
// Notes: instruction codes and the identity value are local choices
package tap_pkg;

    // instruction register width and codes
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] INSTR_EXTEST = 4'h0; // drive pins from the update latches
    localparam logic [3:0] INSTR_SAMPLE = 4'h1; // observe pins, core keeps the pins
    localparam logic [3:0] INSTR_IDCODE = 4'h2; // also the value after controller reset
    localparam logic [3:0] INSTR_BYPASS = 4'hf; // all ones, as the standard demands
    localparam logic [3:0] IR_CAPTURE = 4'h1; // low two bits 01 on capture

    // boundary register length and identity word
    localparam int BSR_LEN = 8;
    // value is arbitrary; bit 0 must stay one
    localparam logic [31:0] IDCODE_DEFAULT = 32'h1a5a_5001;
    localparam int ID_WIDTH = 32;

    // sixteen controller states, one-hot
    typedef enum logic [15:0] {
        st_reset = 16'h0001,
        st_idle = 16'h0002,
        st_sel_dr = 16'h0004,
        st_cap_dr = 16'h0008,
        st_shift_dr = 16'h0010,
        st_exit1_dr = 16'h0020,
        st_pause_dr = 16'h0040,
        st_exit2_dr = 16'h0080,
        st_upd_dr = 16'h0100,
        st_sel_ir = 16'h0200,
        st_cap_ir = 16'h0400,
        st_shift_ir = 16'h0800,
        st_exit1_ir = 16'h1000,
        st_pause_ir = 16'h2000,
        st_exit2_ir = 16'h4000,
        st_upd_ir = 16'h8000
    } tap_state_t;

endpackage

// ---- logic/tap_fifo.sv ----
// Purpose: small valid/ready buffer for captured pin words
// Assumes: one clock, asynchronous active-high reset
// Notes: depth two by default, so one stalled read loses nothing
`timescale 1ns/1ps
module tap_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
    logic [PW-1:0] wr_q; // write pointer
    logic [PW-1:0] rd_q; // read pointer
    logic [CW-1:0] count_q; // words held
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // honest flags: full blocks the source, empty hides stale data
    assign in_ready = (count_q != FULL);
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_q];

    // pointer step with wrap, used by both pointers
    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == LAST) ? '0 : p + 1'b1;
    endfunction

    // storage write
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= step(wr_q);
            if (pop)
                rd_q <= step(rd_q);
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end
endmodule

// ---- logic/boundary_scan_test_port.sv ----
// Purpose: boundary-scan test access port, oversampled on the system clock
// Assumes: test clock far slower than clock (at least four clock periods per half)
// Notes: output-clock pins carry no cell and never pass through this block
`timescale 1ns/1ps
// Summary of operation
// - test reset low clears controller at once
// - serial input taken on test clock rise
// - serial output changes on test clock fall
// - mode select steps standard controller on rise
// - serial output is three-state, port enables it
// - digital pins are scan cells, clocks excluded
module boundary_scan_test_port #(
    parameter int BSR_LEN = tap_pkg::BSR_LEN,
    parameter logic [31:0] IDCODE = tap_pkg::IDCODE_DEFAULT
) (
    // system clock and reset
    input wire logic clock,
    input wire logic reset,
    // test pins from the tester
    input wire logic test_clock,
    input wire logic test_mode_select,
    input wire logic test_serial_in,
    input wire logic test_reset_n,
    // serial output pin, enable low while driven
    output logic test_serial_out,
    output logic test_serial_out_oe_n,
    // sampled pin states from the pad ring
    input wire logic [BSR_LEN-1:0] pin_state,
    input wire logic pin_state_valid,
    output logic pin_state_ready,
    // core output values and pad drive
    input wire logic [BSR_LEN-1:0] core_pin_out,
    output logic [BSR_LEN-1:0] pin_out,
    output logic test_mode
);
    localparam int IRW = tap_pkg::IR_WIDTH;

    // controller is held by either reset; test reset acts without any edge
    wire tap_rst = reset | ~test_reset_n;

    // two-stage synchronisers and a third stage for edge detection
    logic tck_m_q, tck_s_q, tck_p_q;
    logic tms_m_q, tms_s_q;
    logic tdi_m_q, tdi_s_q;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            {tck_m_q, tck_s_q, tck_p_q} <= 3'h0;
            {tms_m_q, tms_s_q, tdi_m_q, tdi_s_q} <= 4'hf;
        end
        else
        begin
            {tck_m_q, tck_s_q, tck_p_q} <= {test_clock, tck_m_q, tck_s_q};
            {tms_m_q, tms_s_q} <= {test_mode_select, tms_m_q};
            {tdi_m_q, tdi_s_q} <= {test_serial_in, tdi_m_q};
        end
    end
    // tms and tdi share the clock's delay, so they line up with the edge
    wire rise = tck_s_q & ~tck_p_q;
    wire fall = ~tck_s_q & tck_p_q;

    // controller state and the instruction in force
    tap_pkg::tap_state_t state_q; // one-hot controller state
    logic [IRW-1:0] ir_q; // instruction in force
    logic [IRW-1:0] ir_shift_q; // instruction shift stage
    logic [tap_pkg::ID_WIDTH-1:0] id_shift_q; // identity shift stage
    logic bypass_q; // one-bit bypass stage
    logic [BSR_LEN-1:0] bsr_shift_q; // boundary shift stage
    logic [BSR_LEN-1:0] bsr_upd_q; // boundary update latches
    logic [BSR_LEN-1:0] pin_word_q; // latest pad sample out of the buffer
    logic [BSR_LEN-1:0] pin_out_q; // registered pad drive
    logic test_mode_q; // pads under scan control
    logic tdo_q; // serial output bit
    logic tdo_en_q; // serial output driven
    logic buf_valid; // buffer holds a pad word
    logic [BSR_LEN-1:0] buf_data; // oldest pad word in the buffer

    // next controller state for one mode select value
    function automatic tap_pkg::tap_state_t next_state(
        input tap_pkg::tap_state_t s,
        input logic m
    );
        case (s)
            tap_pkg::st_reset: next_state = m ? tap_pkg::st_reset : tap_pkg::st_idle;
            tap_pkg::st_idle: next_state = m ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
            tap_pkg::st_sel_dr: next_state = m ? tap_pkg::st_sel_ir : tap_pkg::st_cap_dr;
            tap_pkg::st_cap_dr: next_state = m ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
            tap_pkg::st_shift_dr: next_state = m ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
            tap_pkg::st_exit1_dr: next_state = m ? tap_pkg::st_upd_dr : tap_pkg::st_pause_dr;
            tap_pkg::st_pause_dr: next_state = m ? tap_pkg::st_exit2_dr : tap_pkg::st_pause_dr;
            tap_pkg::st_exit2_dr: next_state = m ? tap_pkg::st_upd_dr : tap_pkg::st_shift_dr;
            tap_pkg::st_upd_dr: next_state = m ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
            tap_pkg::st_sel_ir: next_state = m ? tap_pkg::st_reset : tap_pkg::st_cap_ir;
            tap_pkg::st_cap_ir: next_state = m ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
            tap_pkg::st_shift_ir: next_state = m ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
            tap_pkg::st_exit1_ir: next_state = m ? tap_pkg::st_upd_ir : tap_pkg::st_pause_ir;
            tap_pkg::st_pause_ir: next_state = m ? tap_pkg::st_exit2_ir : tap_pkg::st_pause_ir;
            tap_pkg::st_exit2_ir: next_state = m ? tap_pkg::st_upd_ir : tap_pkg::st_shift_ir;
            tap_pkg::st_upd_ir: next_state = m ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
            // an illegal code falls back to reset, the safe place
            default: next_state = tap_pkg::st_reset;
        endcase
    endfunction

    // state decode, shared by the stages and the output
    wire in_cap_dr = (state_q == tap_pkg::st_cap_dr);
    wire in_shift_dr = (state_q == tap_pkg::st_shift_dr);
    wire in_upd_dr = (state_q == tap_pkg::st_upd_dr);
    wire in_cap_ir = (state_q == tap_pkg::st_cap_ir);
    wire in_shift_ir = (state_q == tap_pkg::st_shift_ir);
    wire in_upd_ir = (state_q == tap_pkg::st_upd_ir);
    wire in_reset = (state_q == tap_pkg::st_reset);
    wire in_shift = in_shift_dr | in_shift_ir;

    // instruction decode; unknown codes fall through to bypass
    wire sel_id = (ir_q == tap_pkg::INSTR_IDCODE);
    wire sel_extest = (ir_q == tap_pkg::INSTR_EXTEST);
    wire sel_bsr = sel_extest | (ir_q == tap_pkg::INSTR_SAMPLE);
    wire dr_lsb = sel_id ? id_shift_q[0] : (sel_bsr ? bsr_shift_q[0] : bypass_q);
    wire tdo_next = in_shift_ir ? ir_shift_q[0] : dr_lsb;

    // controller steps only on a test clock rise
    always_ff @(posedge clock or posedge tap_rst)
    begin
        if (tap_rst)
            state_q <= tap_pkg::st_reset;
        else if (rise)
            state_q <= next_state(state_q, tms_s_q);
    end

    // instruction register: capture, shift lsb first, update
    always_ff @(posedge clock or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            ir_q <= tap_pkg::INSTR_IDCODE;
            ir_shift_q <= tap_pkg::IR_CAPTURE;
        end
        else if (rise)
        begin
            // reset state keeps the identity instruction in force
            if (in_reset)
                ir_q <= tap_pkg::INSTR_IDCODE;
            else if (in_upd_ir)
                ir_q <= ir_shift_q;
            if (in_cap_ir)
                ir_shift_q <= tap_pkg::IR_CAPTURE;
            else if (in_shift_ir)
                ir_shift_q <= {tdi_s_q, ir_shift_q[IRW-1:1]};
        end
    end

    // data stages: all capture together, only the selected one shifts
    always_ff @(posedge clock or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            id_shift_q <= '0;
            bypass_q <= 1'b0;
            bsr_shift_q <= '0;
        end
        else if (rise && in_cap_dr)
        begin
            id_shift_q <= IDCODE;
            bypass_q <= 1'b0;
            bsr_shift_q <= pin_word_q;
        end
        else if (rise && in_shift_dr)
        begin
            if (sel_id)
                id_shift_q <= {tdi_s_q, id_shift_q[tap_pkg::ID_WIDTH-1:1]};
            else if (sel_bsr)
                bsr_shift_q <= {tdi_s_q, bsr_shift_q[BSR_LEN-1:1]};
            else
                bypass_q <= tdi_s_q;
        end
    end

    // update latches hold the scanned word steady while shifting goes on
    always_ff @(posedge clock or posedge tap_rst)
    begin
        if (tap_rst)
            bsr_upd_q <= '0;
        else if (rise && in_upd_dr && sel_bsr)
            bsr_upd_q <= bsr_shift_q;
    end

    // pad words arrive through a small buffer so a busy pad ring loses none
    tap_fifo #(
        .WIDTH(BSR_LEN),
        .DEPTH(2)
    ) u_pin_buf (
        .clock(clock),
        .reset(reset),
        .in_valid(pin_state_valid),
        .in_ready(pin_state_ready),
        .in_data(pin_state),
        .out_valid(buf_valid),
        .out_ready(1'b1),
        .out_data(buf_data)
    );

    // pad side: newest sample kept, drive chosen by the instruction
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pin_word_q <= '0;
            pin_out_q <= '0;
            test_mode_q <= 1'b0;
        end
        else
        begin
            if (buf_valid)
                pin_word_q <= buf_data;
            // output-clock pins never reach this mux, so they keep running
            pin_out_q <= sel_extest ? bsr_upd_q : core_pin_out;
            test_mode_q <= sel_extest;
        end
    end

    // serial output moves only on a test clock fall, half a period before use
    always_ff @(posedge clock or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            tdo_q <= 1'b0;
            tdo_en_q <= 1'b0;
        end
        else if (fall)
        begin
            tdo_en_q <= in_shift;
            if (in_shift)
                tdo_q <= tdo_next;
        end
    end

    // pins: enable is active low, the pad turns it into a three-state driver
    assign test_serial_out = tdo_q;
    assign test_serial_out_oe_n = ~tdo_en_q;
    assign pin_out = pin_out_q;
    assign test_mode = test_mode_q;

    // test reset holds the controller and releases the output at once
    trst_holds_a: assert property (@(posedge clock) disable iff (reset)
        !test_reset_n |-> (state_q == tap_pkg::st_reset) && !tdo_en_q)
        else $error("controller not held by test reset");
    // instruction bits enter at the top on a rise
    ir_shift_in_a: assert property (@(posedge clock) disable iff (tap_rst)
        rise && in_shift_ir |=> ir_shift_q == {$past(tdi_s_q), $past(ir_shift_q[IRW-1:1])})
        else $error("instruction shift lost a bit");
    // output bit and enable move only after a fall
    tdo_on_fall_a: assert property (@(posedge clock) disable iff (tap_rst)
        !fall |=> $stable(tdo_q) && $stable(tdo_en_q))
        else $error("serial output moved without a fall");
    // controller moves only after a rise
    state_on_rise_a: assert property (@(posedge clock) disable iff (tap_rst)
        !rise |=> $stable(state_q))
        else $error("controller moved without a rise");
    // at each fall the output enable takes whether the controller is shifting
    oe_follows_shift_a: assert property (@(posedge clock) disable iff (tap_rst)
        fall |=> tdo_en_q == $past(in_shift))
        else $error("output enable not tied to shift states");
    // scanned word drives the pads under extest
    extest_pins_a: assert property (@(posedge clock) disable iff (reset)
        sel_extest |=> pin_out_q == $past(bsr_upd_q))
        else $error("pads not driven from update latches");
    // core keeps the pads otherwise
    core_pins_a: assert property (@(posedge clock) disable iff (reset)
        !sel_extest |=> pin_out_q == $past(core_pin_out))
        else $error("pads not driven by the core");

    // main scenarios reached
    id_shift_c: cover property (@(posedge clock) rise && in_shift_dr && sel_id);
    ir_update_c: cover property (@(posedge clock) rise && in_upd_ir);
    extest_update_c: cover property (@(posedge clock) rise && in_upd_dr && sel_extest);
endmodule

// ---- dv/test_controller_model.sv ----
// Purpose: tester model that drives the test pins of the port
// Assumes: test clock stands low between frames, 320 ns period
// Notes: serial input holds its value until the next step sets it
`timescale 1ns/1ps
module test_controller_model (
    // pins driven toward the port
    output logic test_clock = 1'b0,
    output logic test_mode_select = 1'b1,
    output logic test_serial_in = 1'b0,
    output logic test_reset_n = 1'b0,
    // answer from the port
    input wire logic test_serial_out,
    input wire logic test_serial_out_oe_n
);
    // one test clock period; inputs set at the fall, answer taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        test_mode_select = m;
        test_serial_in = d;
        #160 test_clock = 1'b1;
        // an undriven output reads as unknown, so a match needs a real drive
        q = test_serial_out_oe_n ? 1'bx : test_serial_out;
        #160 test_clock = 1'b0;
    endtask
endmodule

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the test port
// Assumes: tester model drives the test pins at falling system edges
// Notes: pad words are held fixed, the buffer path is only lightly reached
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0, reset, tck, tms, tdi, trst_n, tdo, oe_n;
    logic [63:0] seen;
    logic [7:0] pins;
    logic tmode;
    int errors = 0;
    int n_compared = 0;
    // port under test, pads at a fixed pattern
    boundary_scan_test_port u_dut (.clock(clock), .reset(reset), .test_clock(tck),
        .test_mode_select(tms), .test_serial_in(tdi), .test_reset_n(trst_n),
        .test_serial_out(tdo), .test_serial_out_oe_n(oe_n), .pin_state(8'h3c),
        .pin_state_valid(1'b1), .pin_state_ready(), .core_pin_out(8'h00),
        .pin_out(pins), .test_mode(tmode));
    test_controller_model u_tester (.test_clock(tck), .test_mode_select(tms),
        .test_serial_in(tdi), .test_reset_n(trst_n), .test_serial_out(tdo),
        .test_serial_out_oe_n(oe_n));
    // 25 MHz system clock
    initial forever #20 clock = ~clock;
    task automatic check(string s, logic [63:0] got, logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", s, exp, got);
        end
    endtask
    // n test clock periods, select and data taken lsb first
    task automatic walk(logic [63:0] m, logic [63:0] d, int n);
        logic b;
        for (int i = 0; i < n; i++)
        begin
            u_tester.step(m[i], d[i], b);
            seen[i] = b;
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // identity word shifted out, output released in idle
    task automatic read_id();
        walk(64'h0000_0018_0000_0002, 64'h0, 38);
        check("id", seen[35:4], {32'h0, tap_pkg::IDCODE_DEFAULT});
        check("idle oe", {63'h0, oe_n}, 64'h1);
    endtask
    // instruction capture, then bypass delays data by one period
    task automatic ir_bypass();
        walk(64'h183, 64'hf0, 10);
        check("ir", {60'h0, seen[7:4]}, {60'h0, tap_pkg::IR_CAPTURE});
        walk(64'hc01, 64'h528, 13);
        check("bypass", {56'h0, seen[10:3]}, 64'h4a);
    endtask
    // extest: pad word scanned out, scanned word driven on the pins
    task automatic extest_pins();
        walk(64'h183, 64'h00, 10);
        walk(64'hc01, 64'h2d0, 13);
        check("capture", {56'h0, seen[10:3]}, 64'h3c);
        check("pins", {56'h0, pins}, 64'h5a);
        check("mode", {63'h0, tmode}, 64'h1);
    endtask
    // test reset in mid-shift with the test clock standing still
    task automatic reset_mid_shift();
        walk(64'h1, 64'h0, 3);
        repeat (4) @(negedge clock);
        check("shift oe", {63'h0, oe_n}, 64'h0);
        u_tester.test_reset_n = 1'b0;
        repeat (4) @(negedge clock);
        check("reset oe", {63'h0, oe_n}, 64'h1);
        check("reset mode", {63'h0, tmode}, 64'h0);
        u_tester.test_reset_n = 1'b1;
    endtask
    // main sequence; a second identity read proves the reset took hold
    initial
    begin
        reset = 1'b1;
        repeat (8) @(negedge clock);
        reset = 1'b0;
        u_tester.test_reset_n = 1'b1;
        repeat (4) @(negedge clock);
        read_id();
        ir_bypass();
        extest_pins();
        reset_mid_shift();
        read_id();
        tally_and_finish();
    end
    // watchdog, several times the expected run
    initial
    begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule
